//--- design/gidp_pkg.sv
// Package of addresses, reset values and mode codes for the general I/O data ports.
// Operation
// [RULE_01] Ports J and K read the stored bit when a pin is a general output.
// [RULE_02] Any pin in input mode, code 10 or 11, reads its sampled pin level.
// [RULE_03] Port J data clears on power-on reset and survives manual reset and standby.
// [RULE_04] Port K data clears on power-on reset and survives manual reset and standby.
// [RULE_05] In output mode a write stores the bit and drives it onto the pin.
// [RULE_06] In other modes a write stores the bit only; mode 00 reads the bit.
// [RULE_07] In input mode the pull-up is on for code 10 and off for code 11.
// [RULE_08] Port L is an 8-bit read-only register; writes change nothing.
// [RULE_09] Port L reads zero for codes 00 and 01 and the pin level otherwise.
// [RULE_10] Port L pins have no pull-up; both input codes behave the same.
// [RULE_11] Port L reads zero after power-on reset and keeps that through manual reset.
// [RULE_12] Serial port data bits 6 to 0 are read/write and bit 7 is read-only.
// [RULE_13] Serial port bits 6 to 0 clear on power-on reset and survive manual reset.
// [RULE_14] After reset serial pins are inputs with pull-up and their levels read back.
// [RULE_15] Serial bit 7 reads low except in input mode; writes to it are ignored.
// [RULE_16] Software sets receive enable before reading receive pins while the link is enabled.
// [RULE_17] Every pin input passes two clocked flip-flops before a register read sees it.
package gidp_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] GIDP_J_IDX = 32'h04000130;
  localparam logic [31:0] GIDP_K_IDX = 32'h04000132;
  localparam logic [31:0] GIDP_L_IDX = 32'h04000134;
  localparam logic [31:0] GIDP_SC_IDX = 32'h04000136;
  localparam logic [31:0] GIDP_J_ADDR = GIDP_J_IDX << 2;
  localparam logic [31:0] GIDP_K_ADDR = GIDP_K_IDX << 2;
  localparam logic [31:0] GIDP_L_ADDR = GIDP_L_IDX << 2;
  localparam logic [31:0] GIDP_SC_ADDR = GIDP_SC_IDX << 2;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int GIDP_PORT_W = 8;
  localparam int GIDP_SC_RW_W = 7;
  localparam int GIDP_SC_IN_BIT = 7;
  localparam logic [7:0] GIDP_J_RESET = 8'h00;
  localparam logic [7:0] GIDP_K_RESET = 8'h00;
  localparam logic [7:0] GIDP_L_READ_OFF = 8'h00;
  localparam logic [6:0] GIDP_SC_RESET = 7'h00;
  localparam logic [31:0] GIDP_RDATA_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Pin mode codes and bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] GIDP_MODE_OTHER = 2'h0;
  localparam logic [1:0] GIDP_MODE_OUTPUT = 2'h1;
  localparam logic [1:0] GIDP_MODE_IN_PU = 2'h2;
  localparam logic [1:0] GIDP_MODE_IN_NOPU = 2'h3;
  localparam logic GIDP_HRESP_OKAY = 1'h0;
  localparam logic [1:0] GIDP_SYNC_RESET = 2'h0;

endpackage

//--- design/gidp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps

module gidp_sync #(
  parameter int W = 8
) (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Raw pins and synchronised levels.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // Synchronising stages
  // ----------------------------------------------------------------
  // The first stage feeds only the second, so a metastable level never spreads.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta <= async_in; // RULE_17
      sync_out <= meta; // RULE_17
    end
  end

endmodule

//--- design/gidp_ports.sv
// Data registers and pin logic of ports J, K, L and the serial pin port, with AHB-Lite access.
`timescale 1ns/100ps

module gidp_ports
  import gidp_pkg::*;
(
  // Clock, power-on reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pin modes from the pin function controller.
  input wire logic [7:0] j_pin_mode_high,
  input wire logic [7:0] j_pin_mode_low,
  input wire logic [7:0] k_pin_mode_high,
  input wire logic [7:0] k_pin_mode_low,
  input wire logic [7:0] l_pin_mode_high,
  input wire logic [7:0] l_pin_mode_low,
  input wire logic [7:0] serial_pin_mode_high,
  input wire logic [7:0] serial_pin_mode_low,
  // Port J pins.
  input wire logic [7:0] j_pins_in,
  output logic [7:0] j_pins_out,
  output logic [7:0] j_pins_oe,
  output logic [7:0] j_pins_pullup,
  // Port K pins.
  input wire logic [7:0] k_pins_in,
  output logic [7:0] k_pins_out,
  output logic [7:0] k_pins_oe,
  output logic [7:0] k_pins_pullup,
  // Port L input-only pins.
  input wire logic [7:0] l_pins_in,
  // Serial port pins; bit 7 is input only.
  input wire logic [7:0] serial_port_pins_in,
  output logic [6:0] serial_port_pins_out,
  output logic [6:0] serial_port_pins_oe,
  output logic [7:0] serial_port_pins_pullup
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] port_j_data;
  logic [7:0] port_k_data;
  logic [6:0] serial_pin_port_data;
  logic [7:0] j_sync;
  logic [7:0] k_sync;
  logic [7:0] l_sync;
  logic [7:0] sc_sync;
  logic take;
  logic wr_j_q;
  logic wr_k_q;
  logic wr_sc_q;
  logic do_wr_j;
  logic do_wr_k;
  logic do_wr_sc;
  logic [7:0] next_port_j_data;
  logic [7:0] next_port_k_data;
  logic [6:0] next_serial_pin_port_data;
  logic [7:0] j_in_mask;
  logic [7:0] k_in_mask;
  logic [7:0] j_rd;
  logic [7:0] k_rd;
  logic [7:0] l_rd;
  logic [7:0] sc_rd;
  logic [31:0] next_hrdata;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  gidp_sync #(.W(GIDP_PORT_W)) u_sync_j (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(j_pins_in), .sync_out(j_sync)
  );
  gidp_sync #(.W(GIDP_PORT_W)) u_sync_k (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(k_pins_in), .sync_out(k_sync)
  );
  gidp_sync #(.W(GIDP_PORT_W)) u_sync_l (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(l_pins_in), .sync_out(l_sync) // RULE_11
  );
  gidp_sync #(.W(GIDP_PORT_W)) u_sync_sc (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(serial_port_pins_in), .sync_out(sc_sync)
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Stretching the data phase while the enable is low keeps the bus from losing transfers.
  assign hreadyout = ce;
  assign hresp = GIDP_HRESP_OKAY;
  assign take = ce && hready && hsel && htrans[1];

  // Address phase capture of the write targets.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_j_q <= 1'b0;
      wr_k_q <= 1'b0;
      wr_sc_q <= 1'b0;
    end else if (ce) begin
      wr_j_q <= take && hwrite && (haddr == GIDP_J_ADDR);
      wr_k_q <= take && hwrite && (haddr == GIDP_K_ADDR);
      wr_sc_q <= take && hwrite && (haddr == GIDP_SC_ADDR);
    end
  end

  // Writes land in the data phase; port L has no write path at all.
  assign do_wr_j = ce && wr_j_q;
  assign do_wr_k = ce && wr_k_q;
  assign do_wr_sc = ce && wr_sc_q;
  assign next_port_j_data = do_wr_j ? hwdata[7:0] : port_j_data; // RULE_06
  assign next_port_k_data = do_wr_k ? hwdata[7:0] : port_k_data; // RULE_06
  assign next_serial_pin_port_data = do_wr_sc ? hwdata[6:0] : serial_pin_port_data; // RULE_12

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Only power-on reset clears the ports; manual reset and standby never reach here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_j_data <= GIDP_J_RESET; // RULE_03
    end else if (ce) begin
      port_j_data <= next_port_j_data;
    end
  end

  // Port K data register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_k_data <= GIDP_K_RESET; // RULE_04
    end else if (ce) begin
      port_k_data <= next_port_k_data;
    end
  end

  // Serial port bits 6 to 0; bit 7 has no storage, so it is never written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_pin_port_data <= GIDP_SC_RESET; // RULE_13
    end else if (ce) begin
      serial_pin_port_data <= next_serial_pin_port_data; // RULE_15
    end
  end

  // ----------------------------------------------------------------
  // Per-bit pin and read logic
  // ----------------------------------------------------------------
  // Reads use the next register values so a read right after a write sees the new data.
  for (genvar i = 0; i < GIDP_PORT_W; i++) begin : g_bit
    assign j_in_mask[i] = j_pin_mode_high[i]; // RULE_02
    assign k_in_mask[i] = k_pin_mode_high[i]; // RULE_02
    assign j_rd[i] = j_in_mask[i] ? j_sync[i] : next_port_j_data[i]; // RULE_01
    assign k_rd[i] = k_in_mask[i] ? k_sync[i] : next_port_k_data[i]; // RULE_01
    assign l_rd[i] = l_pin_mode_high[i] ? l_sync[i] : GIDP_L_READ_OFF[i]; // RULE_09 RULE_10
    assign j_pins_out[i] = port_j_data[i];
    assign k_pins_out[i] = port_k_data[i];
    assign j_pins_oe[i] = ({j_pin_mode_high[i], j_pin_mode_low[i]} == GIDP_MODE_OUTPUT); // RULE_05
    assign k_pins_oe[i] = ({k_pin_mode_high[i], k_pin_mode_low[i]} == GIDP_MODE_OUTPUT); // RULE_05
    assign j_pins_pullup[i] = ({j_pin_mode_high[i], j_pin_mode_low[i]} == GIDP_MODE_IN_PU); // RULE_07
    assign k_pins_pullup[i] = ({k_pin_mode_high[i], k_pin_mode_low[i]} == GIDP_MODE_IN_PU); // RULE_07
    assign serial_port_pins_pullup[i] =
      ({serial_pin_mode_high[i], serial_pin_mode_low[i]} == GIDP_MODE_IN_PU); // RULE_07
    if (i == GIDP_SC_IN_BIT) begin : g_sc_in
      // Input-only bit reads low outside the input modes.
      assign sc_rd[i] = serial_pin_mode_high[i] & sc_sync[i]; // RULE_15
    end else begin : g_sc_io
      assign sc_rd[i] = serial_pin_mode_high[i] ? sc_sync[i] :
        next_serial_pin_port_data[i]; // RULE_14
      assign serial_port_pins_out[i] = serial_pin_port_data[i];
      assign serial_port_pins_oe[i] =
        ({serial_pin_mode_high[i], serial_pin_mode_low[i]} == GIDP_MODE_OUTPUT); // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero with an OKAY answer; upper bits always read zero.
  always_comb begin
    next_hrdata = GIDP_RDATA_RESET;
    if (take && !hwrite) begin
      if (haddr == GIDP_J_ADDR) begin
        next_hrdata[7:0] = j_rd;
      end else if (haddr == GIDP_K_ADDR) begin
        next_hrdata[7:0] = k_rd;
      end else if (haddr == GIDP_L_ADDR) begin
        next_hrdata[7:0] = l_rd; // RULE_08
      end else if (haddr == GIDP_SC_ADDR) begin
        next_hrdata[7:0] = sc_rd; // RULE_12
      end
    end
  end

  // Read data is registered at the address phase and stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= GIDP_RDATA_RESET;
    end else if (take) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  logic j_written;
  logic k_written;
  logic sc_written;
  logic [1:0] settle;
  logic rd_j;
  logic rd_k;
  logic rd_l;
  logic rd_sc;

  assign rd_j = take && !hwrite && (haddr == GIDP_J_ADDR);
  assign rd_k = take && !hwrite && (haddr == GIDP_K_ADDR);
  assign rd_l = take && !hwrite && (haddr == GIDP_L_ADDR);
  assign rd_sc = take && !hwrite && (haddr == GIDP_SC_ADDR);

  // Track whether each register has been written and whether the synchronisers are full.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      j_written <= 1'b0;
      k_written <= 1'b0;
      sc_written <= 1'b0;
      settle <= GIDP_SYNC_RESET;
    end else begin
      j_written <= j_written || do_wr_j;
      k_written <= k_written || do_wr_k;
      sc_written <= sc_written || do_wr_sc;
      if (ce && settle != 2'h3) begin
        settle <= settle + 2'h1;
      end else if (!ce) begin
        settle <= GIDP_SYNC_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_out_reads_reg;
    rd_j |=> ((hrdata[7:0] ^ port_j_data) & $past(j_pins_oe)) == 8'h00;
  endproperty
  a_out_reads_reg: assert property (p_out_reads_reg) // RULE_01
    else $error("Port J output pin did not read its stored bit.");

  property p_in_reads_pin;
    rd_j |=> ((hrdata[7:0] ^ $past(j_sync)) & $past(j_in_mask)) == 8'h00;
  endproperty
  a_in_reads_pin: assert property (p_in_reads_pin) // RULE_02
    else $error("Port J input pin did not read its pin level.");

  property p_j_reset_zero;
    !j_written |-> port_j_data == GIDP_J_RESET;
  endproperty
  a_j_reset_zero: assert property (p_j_reset_zero) // RULE_03
    else $error("Port J data changed without a write.");

  property p_k_reset_zero;
    !k_written |-> port_k_data == GIDP_K_RESET;
  endproperty
  a_k_reset_zero: assert property (p_k_reset_zero) // RULE_04
    else $error("Port K data changed without a write.");

  property p_write_drives_pin;
    do_wr_k |=> k_pins_out == $past(hwdata[7:0]);
  endproperty
  a_write_drives_pin: assert property (p_write_drives_pin) // RULE_05
    else $error("Port K write did not reach the pin.");

  property p_pullup_code;
    j_pins_pullup == (j_pin_mode_high & ~j_pin_mode_low) && (j_pins_oe & j_pins_pullup) == 8'h00;
  endproperty
  a_pullup_code: assert property (p_pullup_code) // RULE_07
    else $error("Pull-up does not follow the input mode code.");

  property p_l_read;
    rd_l |=> hrdata == {24'h000000, $past(l_sync) & $past(l_pin_mode_high)};
  endproperty
  a_l_read: assert property (p_l_read) // RULE_09
    else $error("Port L read returned the wrong value.");

  property p_sc_bit7;
    rd_sc |=> hrdata[7] == ($past(serial_pin_mode_high[7]) && $past(sc_sync[7]));
  endproperty
  a_sc_bit7: assert property (p_sc_bit7) // RULE_15
    else $error("Serial bit 7 read wrong outside input mode.");

  property p_sc_write;
    do_wr_sc |=> serial_pin_port_data == $past(hwdata[6:0]);
  endproperty
  a_sc_write: assert property (p_sc_write) // RULE_12
    else $error("Serial port bits 6 to 0 not written.");

  property p_sc_reset_zero;
    !sc_written |-> serial_pin_port_data == GIDP_SC_RESET;
  endproperty
  a_sc_reset_zero: assert property (p_sc_reset_zero) // RULE_13
    else $error("Serial port data changed without a write.");

  property p_sync_depth;
    (settle == 2'h3) && ce |-> l_sync == $past(l_pins_in, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth) // RULE_17
    else $error("Pin level not delayed by exactly two flops.");

  // A frozen cycle must leave every stored bit and the read data exactly where they were.
  property p_ce_freeze;
    !ce |=> port_j_data == $past(port_j_data) && port_k_data == $past(port_k_data) &&
      serial_pin_port_data == $past(serial_pin_port_data) && hrdata == $past(hrdata);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) // RULE_03 RULE_04 RULE_13
    else $error("State moved while the clock enable was low.");

  property p_oe_code;
    j_pins_oe == (~j_pin_mode_high & j_pin_mode_low) &&
      k_pins_oe == (~k_pin_mode_high & k_pin_mode_low);
  endproperty
  a_oe_code: assert property (p_oe_code) // RULE_06
    else $error("Pin driven outside the output mode.");

  property p_k_stored_read;
    rd_k |=> ((hrdata[7:0] ^ port_k_data) & ~$past(k_in_mask)) == 8'h00;
  endproperty
  a_k_stored_read: assert property (p_k_stored_read) // RULE_06
    else $error("Port K non-input pin did not read its stored bit.");

  property p_sc_stored_read;
    rd_sc |=>
      ((hrdata[6:0] ^ serial_pin_port_data) & ~$past(serial_pin_mode_high[6:0])) == 7'h00;
  endproperty
  a_sc_stored_read: assert property (p_sc_stored_read) // RULE_12
    else $error("Serial non-input pin did not read its stored bit.");

  c_write_j: cover property (do_wr_j ##1 rd_j);
  c_read_l_input: cover property (rd_l && l_pin_mode_high != 8'h00);
  c_sc_output: cover property (do_wr_sc ##1 serial_port_pins_oe != 7'h00);
  c_ce_stall: cover property (!ce ##1 ce && (wr_j_q || wr_k_q || wr_sc_q));

endmodule

//--- sim/test_general_io_data_ports.sv
// Self-checking testbench of the general I/O data ports block.
`timescale 1ns/100ps

module test_general_io_data_ports;
  import gidp_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] jmh, jml, kmh, kml, lmh, lml, smh, sml;
  logic [7:0] j_in, k_in, l_in, s_in, j_out, j_oe, j_pu, k_out, k_oe, k_pu, s_pu;
  logic [6:0] s_out, s_oe, s_st;
  logic [7:0] j_st, k_st;
  logic [31:0] addrs [5];
  logic [7:0] exp_q [$];
  logic rd_dp;
  logic stall_en;
  int err_total, n_tests;

  // The single slave drives the bus ready.
  assign hready = hreadyout;

  gidp_ports DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .j_pin_mode_high(jmh), .j_pin_mode_low(jml), .k_pin_mode_high(kmh),
    .k_pin_mode_low(kml), .l_pin_mode_high(lmh), .l_pin_mode_low(lml),
    .serial_pin_mode_high(smh), .serial_pin_mode_low(sml),
    .j_pins_in(j_in), .j_pins_out(j_out), .j_pins_oe(j_oe), .j_pins_pullup(j_pu),
    .k_pins_in(k_in), .k_pins_out(k_out), .k_pins_oe(k_oe), .k_pins_pullup(k_pu),
    .l_pins_in(l_in),
    .serial_port_pins_in(s_in), .serial_port_pins_out(s_out),
    .serial_port_pins_oe(s_oe), .serial_port_pins_pullup(s_pu)
  );

  // Free-running 100 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Compare tasks and closing report
  // ----------------------------------------------------------------
  task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s is %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0) begin
      err_total++;
      $display("ERROR %0t %0d reads were never answered", $time, exp_q.size());
    end
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read monitor: takes the oldest expected value per read data phase
  // ----------------------------------------------------------------
  // Random clock-enable drops while stalls are allowed; the master must wait them out.
  always @(posedge hclk) begin
    ce <= !(stall_en && ($urandom_range(3, 0) == 0));
  end

  // The data-phase flag only advances when the bus is ready, so a stall keeps it.
  always @(posedge hclk) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
    end else if (hready === 1'b1) begin
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  // Sampling at the falling edge keeps clear of the registered read data update.
  always @(negedge hclk) begin
    if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("ERROR %0t read data with no expected value", $time);
      end else begin
        check_read(hrdata, {24'h000000, exp_q.pop_front()});
      end
      check_pin("hresp", {7'h00, hresp}, {7'h00, GIDP_HRESP_OKAY});
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite master tasks
  // ----------------------------------------------------------------
  // Bounded wait for a ready edge; a hang is reported and ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_total++;
      $display("ERROR %0t bus ready never came", $time);
      finish_test();
    end
  endtask

  // Entered just after a rising edge; returns at the edge ending the data phase.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  // Every write to J, K or the serial port lands in the stored bits whatever the mode; port L, bit 7 and the unmapped word keep nothing.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a === GIDP_J_ADDR) j_st = d[7:0];
    if (a === GIDP_K_ADDR) k_st = d[7:0];
    if (a === GIDP_SC_ADDR) s_st = d[6:0];
  endtask

  // Input-mode bits read the pin, all other bits the stored value.
  function automatic logic [7:0] rexp(input logic [7:0] st, input logic [7:0] pin,
                                      input logic [7:0] mh);
    return (pin & mh) | (st & ~mh);
  endfunction

  // Reads every register and an unmapped word, then checks the pin drivers.
  task automatic check_all();
    rd(GIDP_J_ADDR, rexp(j_st, j_in, jmh));
    rd(GIDP_K_ADDR, rexp(k_st, k_in, kmh));
    rd(GIDP_L_ADDR, rexp(8'h00, l_in, lmh));
    rd(GIDP_SC_ADDR, rexp({1'b0, s_st}, s_in, smh));
    rd(GIDP_SC_ADDR + 32'h4, 8'h00);
    check_pin("j out", j_out, j_st);
    check_pin("j oe", j_oe, ~jmh & jml);
    check_pin("j pullup", j_pu, jmh & ~jml);
    check_pin("k out", k_out, k_st);
    check_pin("k oe", k_oe, ~kmh & kml);
    check_pin("k pullup", k_pu, kmh & ~kml);
    check_pin("s out", {1'b0, s_out}, {1'b0, s_st});
    check_pin("s oe", {1'b0, s_oe}, {1'b0, ~smh[6:0] & sml[6:0]});
    check_pin("s pullup", s_pu, smh & ~sml);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6612576e));
    addrs = '{GIDP_J_ADDR, GIDP_K_ADDR, GIDP_L_ADDR, GIDP_SC_ADDR, GIDP_SC_ADDR + 32'h4};
    err_total = 0;
    n_tests = 0;
    hresetn = 1'b0;
    stall_en = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    {jmh, jml, kmh, kml, lmh, lml, smh, sml} = 64'h0;
    {j_in, k_in, l_in, s_in} = 32'h0;
    j_st = 8'h00;
    k_st = 8'h00;
    s_st = 7'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values with every pin in its other function.
    check_all();
    // Serial pins as inputs with pull-up: levels must read back on all input bits.
    // Software has already made the receive pins inputs, so they read like the rest.
    smh <= 8'hFF;
    s_in <= 8'($urandom);
    repeat (3) @(posedge hclk);
    check_all();
    // Random modes per pin, random pin levels and a random write target.
    for (int i = 0; i < 40; i++) begin
      {jmh, jml, kmh, kml, lmh, lml, smh, sml} <= {$urandom, $urandom};
      {j_in, k_in, l_in, s_in} <= $urandom;
      repeat (3) @(posedge hclk);
      wr(addrs[$urandom_range(4, 0)], $urandom);
      check_all();
    end
    // Clock-enable stalls with modes and pins held, so the frozen synchronisers stay valid.
    stall_en <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      wr(addrs[$urandom_range(4, 0)], $urandom);
      check_all();
    end
    stall_en <= 1'b0;
    // A second power-on reset in mid-run clears all stored bits again.
    hresetn <= 1'b0;
    {jmh, jml, kmh, kml, lmh, lml, smh, sml} <= 64'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    j_st = 8'h00;
    k_st = 8'h00;
    s_st = 7'h00;
    @(posedge hclk);
    check_all();
    finish_test();
  end

endmodule
